// ---- verilog/rail_sequence_group_control.sv ----
/*
  Rail sequencing and group membership control of one output page.
  Holds the loop compensation, rail order and group words, answers
  events from peers on the shared event bus and decides output on/off.
  Assumes the command decoder and event bus receiver run on sys_clk and
  deliver one-cycle requests; strap inputs are static pins.
*/
// Notes on behaviour
// - With prequel on, turn on only when enabled and prequel rail sent power good.
// - With sequel on, start delayed turn-off once sequel rail sent power down.
// - Rail order word: prequel ID bits 12:8, sequel ID bits 4:0, others unused.
// - Bit 15 enables prequel, bit 7 enables sequel, activating the byte's ID.
// - A cleared enable bit means no predecessor or follower; the ID is ignored.
// - A written rail order word overrides the strap-selected sequencing setup.
// - Rail order word resets to zero, both modes off; read/write.
// - Group bit 21 allows broadcast voltage commands for own voltage group.
// - Bits 20:16 hold the voltage group ID compared with the event ID.
// - Group bit 13 allows broadcast operation commands for own group.
// - Bits 12:8 hold the operation group ID compared with the event ID.
// - Bit 5 set: matching power fail shuts output down at once.
// - Bit 5 clear: matching power fail gives a sequenced shutdown.
// - Bits 4:0 hold power fail group ID, sent out and matched on receive.
// - In two-phase sharing, power fail responses spread over phases regardless.
// - Group IDs and rail IDs are matched independently, never inferred.
// - Loop compensation word resets from the compensation strap decode.
`timescale 1ns/10ps
`default_nettype none
module rail_sequence_group_control
  import rail_seq_pkg::*;
(
  input  wire logic        sys_clk,             // 50 MHz clock
  input  wire logic        rst_n,               // Asynchronous reset, active low
  input  wire reg_req_t    req,                 // Command write or read, one-cycle strobes
  output logic [31:0]      rdata,               // Read data, valid the cycle after rd
  input  wire logic [7:0]  comp_strap_gain,     // Compensation strap decoded gain
  input  wire logic [7:0]  comp_strap_residual, // Compensation strap decoded residual
  input  wire logic [15:0] strap_rail_order,    // Sequencing setup chosen by config strap
  input  wire logic [31:0] strap_group,         // Group word chosen by config strap
  input  wire logic        two_phase_share,     // Event bus setup selects 2-phase sharing
  input  wire logic        phase_sel,           // This controller's phase, 0 or 1
  input  wire logic        enable_request,      // Enable pin or operation state active
  input  wire bus_event_t  evt,                 // Event received from the shared bus
  output logic             output_on,           // Output stage enable
  output logic             sequenced_off,       // Output off after programmed delays
  output logic             vout_accept,         // Broadcast voltage command accepted
  output logic             operation_accept,    // Broadcast operation command accepted
  output logic [4:0]       fail_group_id        // ID sent with own power fail events
);

  function automatic logic id_match(input logic en, input logic [4:0] a, input logic [4:0] b);
    id_match = en && (a == b);
  endfunction

  // Kind check of a received event, shared by every matcher below.
  function automatic logic is_event(input bus_event_t e, input event_kind_t k);
    is_event = e.valid && (e.kind == k);
  endfunction

  logic [31:0] loop_comp_q, loop_comp_d;
  logic [15:0] rail_order_q, rail_order_d;
  logic [31:0] group_q, group_d;
  logic        order_written_q, order_written_d;
  logic        group_written_q, group_written_d;
  logic        strap_loaded_q, strap_loaded_d;
  logic [31:0] rdata_d;

  logic [15:0] order_eff;
  logic [31:0] group_eff;

  // The compensation strap is caught in the first clocked cycle after reset release; the rail order and group straps are used live until written.
  always_comb begin
    loop_comp_d     = loop_comp_q;
    rail_order_d    = rail_order_q;
    group_d         = group_q;
    order_written_d = order_written_q;
    group_written_d = group_written_q;
    strap_loaded_d  = 1'b1;
    rdata_d         = rdata;
    if (!strap_loaded_q) begin
      loop_comp_d = {8'h00, comp_strap_residual, 8'h00, comp_strap_gain};
    end
    if (req.wr) begin
      case (req.cmd)
        CMD_LOOP_COMP: loop_comp_d = req.wdata & LOOP_COMP_MASK;
        CMD_RAIL_ORDER: begin
          rail_order_d    = req.wdata[15:0] & RAIL_ORDER_MASK;
          order_written_d = 1'b1;
        end
        CMD_GROUP: begin
          group_d         = req.wdata & GROUP_MASK;
          group_written_d = 1'b1;
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.cmd)
        CMD_LOOP_COMP:  rdata_d = loop_comp_q;
        CMD_RAIL_ORDER: rdata_d = {16'h0000, order_eff};
        CMD_GROUP:      rdata_d = group_eff;
        default:        rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_comp_q     <= 32'h00000000;
      rail_order_q    <= RAIL_ORDER_RESET;
      group_q         <= 32'h00000000;
      order_written_q <= 1'b0;
      group_written_q <= 1'b0;
      strap_loaded_q  <= 1'b0;
      rdata           <= 32'h00000000;
    end else begin
      loop_comp_q     <= loop_comp_d;
      rail_order_q    <= rail_order_d;
      group_q         <= group_d;
      order_written_q <= order_written_d;
      group_written_q <= group_written_d;
      strap_loaded_q  <= strap_loaded_d;
      rdata           <= rdata_d;
    end
  end

  // A written word wins over the strap-selected setup once written.
  assign order_eff = order_written_q ? rail_order_q : (strap_rail_order & RAIL_ORDER_MASK);
  assign group_eff = group_written_q ? group_q : (strap_group & GROUP_MASK);

  logic pre_en, seq_en;
  logic [4:0] pre_id, seq_id;
  assign pre_en = order_eff[RO_PRE_EN_BIT];
  assign seq_en = order_eff[RO_SEQ_EN_BIT];
  assign pre_id = order_eff[RO_PRE_LSB +: 5];
  assign seq_id = order_eff[RO_SEQ_LSB +: 5];

  // Rail events carry rail IDs and group events group IDs; each is compared
  // only within its own kind so that the two ID spaces never cross.
  // Level pins from outside the clock domain pass three flip-flops, and a
  // new level is taken only once the second and third stages agree. A pin
  // glitch shorter than one clock therefore never reaches the on/off logic.
  localparam int PIN_CNT = 3;

  logic [PIN_CNT-1:0] pin_raw;
  wire  [PIN_CNT-1:0] pin_lvl;
  logic               en_lvl;
  logic               share_lvl;
  logic               phase_lvl;

  assign pin_raw = {phase_sel, two_phase_share, enable_request};

  generate
    for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin_sync
      logic s1_q, s1_d;
      logic s2_q, s2_d;
      logic s3_q, s3_d;
      logic lvl_q, lvl_d;

      always_comb begin
        s1_d  = pin_raw[i];
        s2_d  = s1_q;
        s3_d  = s2_q;
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
          lvl_d = s3_q;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q  <= s1_d;
          s2_q  <= s2_d;
          s3_q  <= s3_d;
          lvl_q <= lvl_d;
        end
      end

      assign pin_lvl[i] = lvl_q;
    end
  endgenerate

  assign en_lvl    = pin_lvl[0];
  assign share_lvl = pin_lvl[1];
  assign phase_lvl = pin_lvl[2];

  logic pg_hit;
  logic pd_hit;
  logic pf_hit;
  assign pg_hit = is_event(evt, EV_POWER_GOOD)
                  && id_match(pre_en, pre_id, evt.id);
  assign pd_hit = is_event(evt, EV_POWER_DOWN)
                  && id_match(seq_en, seq_id, evt.id);
  assign pf_hit = is_event(evt, EV_POWER_FAIL)
                  && evt.id == group_eff[GR_PF_LSB +: 5];

  // The power fail ID leaves through a register. It is taken from the
  // next-state words so that it never lags the word the matcher uses.
  logic [4:0] fail_id_q, fail_id_d;

  always_comb begin
    fail_id_d = strap_group[GR_PF_LSB +: 5];
    if (group_written_d) begin
      fail_id_d = group_d[GR_PF_LSB +: 5];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_id_q <= 5'h00;
    end else begin
      fail_id_q <= fail_id_d;
    end
  end

  logic pre_seen_q, pre_seen_d;
  logic on_q, on_d;
  logic held_off_q, held_off_d;
  logic seq_off_q, seq_off_d;
  logic vout_q, vout_d;
  logic oper_q, oper_d;
  logic immediate;
  logic shut_hit;

  // In two-phase sharing the response alternates by phase: phase 0 drops
  // at once, phase 1 sequences, so the fail load is spread over the pair.
  assign immediate = share_lvl ? !phase_lvl : group_eff[GR_PF_EN];

  assign shut_hit = (on_q && pd_hit) || pf_hit;

  // After an event shutdown the rail stays off until the enable drops;
  // otherwise a stale prequel power good would switch it straight back on.
  always_comb begin
    pre_seen_d = pre_seen_q;
    on_d       = on_q;
    held_off_d = held_off_q;
    seq_off_d  = 1'b0;
    vout_d     = is_event(evt, EV_VOUT)
                 && id_match(group_eff[GR_VOUT_EN], group_eff[GR_VOUT_LSB +: 5],
                             evt.id);
    oper_d     = is_event(evt, EV_OPERATION)
                 && id_match(group_eff[GR_OP_EN], group_eff[GR_OP_LSB +: 5],
                             evt.id);
    if (pg_hit) begin
      pre_seen_d = 1'b1;
    end
    if (!en_lvl) begin
      on_d       = 1'b0;
      held_off_d = 1'b0;
      pre_seen_d = pg_hit;
    end else if (!on_q && !held_off_q && (!pre_en || pre_seen_q)) begin
      on_d = 1'b1;
    end
    if (on_q && pd_hit) begin
      on_d      = 1'b0;
      seq_off_d = 1'b1;
    end
    if (pf_hit) begin
      on_d      = 1'b0;
      seq_off_d = on_q && !immediate;
    end
    if (shut_hit && en_lvl) begin
      held_off_d = 1'b1;
      pre_seen_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_seen_q <= 1'b0;
      on_q       <= 1'b0;
      held_off_q <= 1'b0;
      seq_off_q  <= 1'b0;
      vout_q     <= 1'b0;
      oper_q     <= 1'b0;
    end else begin
      pre_seen_q <= pre_seen_d;
      on_q       <= on_d;
      held_off_q <= held_off_d;
      seq_off_q  <= seq_off_d;
      vout_q     <= vout_d;
      oper_q     <= oper_d;
    end
  end

  assign output_on        = on_q;
  assign sequenced_off    = seq_off_q;
  assign vout_accept      = vout_q;
  assign operation_accept = oper_q;
  assign fail_group_id    = fail_id_q;

endmodule
`default_nettype wire

// ---- verilog/rail_seq_pkg.sv ----
/*
  Package for the rail sequencing and group control block: command codes,
  field positions, reset values, event kinds and the carrier structs.
  Assumes a register port that presents one whole command word per write.
*/
`default_nettype none
package rail_seq_pkg;
  localparam logic [7:0] CMD_LOOP_COMP  = 8'hdf;
  localparam logic [7:0] CMD_RAIL_ORDER = 8'he0;
  localparam logic [7:0] CMD_GROUP      = 8'he2;

  localparam int LC_EN_BIT     = 24;
  localparam int LC_USED_BITS  = 25;
  localparam int RO_PRE_EN_BIT = 15;
  localparam int RO_PRE_LSB    = 8;
  localparam int RO_SEQ_EN_BIT = 7;
  localparam int RO_SEQ_LSB    = 0;
  localparam int GR_VOUT_EN    = 21;
  localparam int GR_VOUT_LSB   = 16;
  localparam int GR_OP_EN      = 13;
  localparam int GR_OP_LSB     = 8;
  localparam int GR_PF_EN      = 5;
  localparam int GR_PF_LSB     = 0;

  localparam logic [15:0] RAIL_ORDER_RESET = 16'h0000;
  localparam logic [15:0] RAIL_ORDER_MASK  = 16'h9f9f;
  localparam logic [31:0] GROUP_MASK       = 32'h003f3f3f;
  localparam logic [31:0] LOOP_COMP_MASK   = 32'h01ffffff;

  typedef enum logic [2:0] {
    EV_NONE, EV_POWER_GOOD, EV_POWER_DOWN, EV_POWER_FAIL, EV_VOUT, EV_OPERATION
  } event_kind_t;

  typedef struct packed {
    logic        valid;
    event_kind_t kind;
    logic [4:0]  id;
    logic [15:0] data;
  } bus_event_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [31:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// ---- test/rail_seq_asserts.sv ----
/* Port checks of the rail sequencing block.
   Bound to every block instance; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module rail_seq_asserts
  import rail_seq_pkg::*;
(
  input wire logic        sys_clk,          // clock
  input wire logic        rst_n,            // reset
  input wire reg_req_t    req,              // request
  input wire logic [31:0] rdata,            // read data
  input wire logic        enable_request,   // enable
  input wire bus_event_t  evt,              // event
  input wire logic        output_on,        // output
  input wire logic        sequenced_off,    // pulse
  input wire logic        vout_accept,      // pulse
  input wire logic        operation_accept, // pulse
  input wire logic [4:0]  fail_group_id     // own id
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(c);
    req.rd && req.cmd == c;
  endsequence
  a_order_unused: assert property (
    s_rd(CMD_RAIL_ORDER) |=> (rdata & 32'hffff6060) == 32'h0) else $error("order bits");
  a_group_unused: assert property (
    s_rd(CMD_GROUP) |=> (rdata & 32'hffc0c0c0) == 32'h0) else $error("group bits");
  a_comp_unused: assert property (
    s_rd(CMD_LOOP_COMP) |=> rdata[31:25] == 7'h0) else $error("comp bits");
  a_enable_low: assert property (
    (!enable_request) [*5] |=> !output_on) else $error("on without enable");
  a_vout_cause: assert property (
    vout_accept |-> $past(evt.valid) && $past(evt.kind) == EV_VOUT) else $error("stray vout");
  a_op_cause: assert property (
    operation_accept |-> $past(evt.valid) && $past(evt.kind) == EV_OPERATION)
    else $error("stray op");
  a_seq_drop: assert property (
    sequenced_off |-> !output_on && $past(output_on)) else $error("pulse without drop");
  a_fail_off: assert property (
    evt.valid && evt.kind == EV_POWER_FAIL && evt.id == fail_group_id |=> !output_on)
    else $error("on after fail");
endmodule
bind rail_sequence_group_control rail_seq_asserts rail_seq_asserts_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .enable_request(enable_request),
  .evt(evt), .output_on(output_on), .sequenced_off(sequenced_off), .vout_accept(vout_accept),
  .operation_accept(operation_accept), .fail_group_id(fail_group_id));
`default_nettype wire

// ---- test/rail_seq_peer.sv ----
/* Peer controller on the shared event bus, one event per call.
   Assumes the caller waits for each call to finish. */
`timescale 1ns/10ps
`default_nettype none
module rail_seq_peer
  import rail_seq_pkg::*;
(
  input  wire logic     sys_clk, // clock
  output var bus_event_t evt     // event to the block
);
  initial evt = '{1'b0, EV_NONE, 5'h0, 16'h0};
  // An idle bus shows the inverted ID, so a stale value never looks like a fresh event.
  task automatic send(input event_kind_t kind, input logic [4:0] id);
    @(negedge sys_clk);
    evt <= '{1'b1, kind, id, 16'h0};
    @(negedge sys_clk);
    evt <= '{1'b0, kind, ~id, 16'hffff};
  endtask
endmodule
`default_nettype wire

// ---- test/rail_sequence_group_control_tb.sv ----
/* Self-checking bench of the rail sequencing block.
   Inputs move at falling edges; events come from the peer model. */
`timescale 1ns/10ps
`default_nettype none
module rail_sequence_group_control_tb;
  import rail_seq_pkg::*;
  typedef struct {logic [7:0] c; logic [31:0] w; logic [31:0] x;} reg_row_t;
  typedef struct {logic [31:0] g; event_kind_t k; logic [4:0] id; logic v; logic o;} evt_row_t;
  logic        sys_clk, rst_n, two_phase_share, phase_sel, enable_request;
  logic        output_on, sequenced_off, vout_accept, operation_accept;
  logic [4:0]  fail_group_id;
  logic [31:0] rdata;
  reg_req_t    req;
  bus_event_t  evt;
  int          error_cnt, tests_run, cyc;
  reg_row_t    regs [5] = '{'{CMD_RAIL_ORDER, 32'hffff, 32'h9f9f},
    '{CMD_GROUP, 32'hffffffff, 32'h3f3f3f}, '{CMD_LOOP_COMP, 32'hffffffff, 32'h1ffffff},
    '{8'h55, 32'hffffffff, 32'h0}, '{CMD_RAIL_ORDER, 32'h8583, 32'h8583}};
  evt_row_t    evts [6] = '{'{32'h212203, EV_VOUT, 5'h1, 1'b1, 1'b0},
    '{32'h212203, EV_VOUT, 5'h2, 1'b0, 1'b0}, '{32'h212203, EV_OPERATION, 5'h2, 1'b0, 1'b1},
    '{32'h212203, EV_OPERATION, 5'h1, 1'b0, 1'b0}, '{32'h10203, EV_VOUT, 5'h1, 1'b0, 1'b0},
    '{32'h10203, EV_OPERATION, 5'h2, 1'b0, 1'b0}};
  rail_seq_peer rail_seq_peer_inst (.sys_clk(sys_clk), .evt(evt));
  rail_sequence_group_control rail_sequence_group_control_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .req(req), .rdata(rdata), .comp_strap_gain(8'h2c),
    .comp_strap_residual(8'h5a), .strap_rail_order(16'h0000), .strap_group(32'hffe12503),
    .two_phase_share(two_phase_share), .phase_sel(phase_sel), .enable_request(enable_request),
    .evt(evt), .output_on(output_on), .sequenced_off(sequenced_off),
    .vout_accept(vout_accept), .operation_accept(operation_accept),
    .fail_group_id(fail_group_id));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [31:0] d);
    @(negedge sys_clk);
    req <= '{w, ~w, c, d};
    @(negedge sys_clk);
    req <= '{1'b0, 1'b0, c, d};
  endtask
  // Each power fail case starts from a fresh enable edge so earlier state cannot mask it.
  // The enable pin is filtered by the design, so each level is held well past its latency.
  task automatic enable_cycle();
    @(negedge sys_clk) enable_request <= 1'b0;
    repeat (6) @(negedge sys_clk);
    enable_request <= 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic fail_case(input logic exp_seq);
    enable_cycle();
    rail_seq_peer_inst.send(EV_POWER_GOOD, 5'h5);
    @(negedge sys_clk);
    chk(output_on, 1'b1);
    rail_seq_peer_inst.send(EV_POWER_FAIL, 5'h3);
    chk(output_on, 1'b0);
    chk(sequenced_off, exp_seq);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    req = '{1'b0, 1'b0, 8'h0, 32'h0};
    {rst_n, enable_request, two_phase_share, phase_sel} = 4'h0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rst_n <= 1'b1;
    acc(1'b0, CMD_RAIL_ORDER, 32'h0);
    chk(fail_group_id, 5'h3);
    chk(rdata, 32'h0);
    acc(1'b0, CMD_LOOP_COMP, 32'h0);
    chk(rdata, 32'h5a002c);
    acc(1'b0, CMD_GROUP, 32'h0);
    chk(rdata, 32'h212503);
    foreach (regs[i]) begin
      acc(1'b1, regs[i].c, regs[i].w);
      acc(1'b0, regs[i].c, 32'h0);
      chk(rdata, regs[i].x);
    end
    $display("test registers done");
    foreach (evts[i]) begin
      acc(1'b1, CMD_GROUP, evts[i].g);
      rail_seq_peer_inst.send(evts[i].k, evts[i].id);
      chk(vout_accept, evts[i].v);
      chk(operation_accept, evts[i].o);
    end
    $display("test broadcast done");
    enable_request <= 1'b1;
    repeat (6) @(negedge sys_clk);
    rail_seq_peer_inst.send(EV_POWER_GOOD, 5'h3);
    @(negedge sys_clk);
    chk(output_on, 1'b0);
    rail_seq_peer_inst.send(EV_POWER_GOOD, 5'h5);
    @(negedge sys_clk);
    chk(output_on, 1'b1);
    rail_seq_peer_inst.send(EV_POWER_DOWN, 5'h5);
    chk(output_on, 1'b1);
    rail_seq_peer_inst.send(EV_POWER_DOWN, 5'h3);
    chk(sequenced_off, 1'b1);
    $display("test sequencing done");
    fail_case(1'b1);
    acc(1'b1, CMD_GROUP, 32'h10223);
    fail_case(1'b0);
    two_phase_share <= 1'b1;
    phase_sel <= 1'b1;
    fail_case(1'b1);
    $display("test power fail done");
    acc(1'b1, CMD_RAIL_ORDER, 32'h0503);
    enable_cycle();
    chk(output_on, 1'b1);
    rail_seq_peer_inst.send(EV_POWER_DOWN, 5'h3);
    chk(output_on, 1'b1);
    $display("test disabled links done");
    report_and_stop();
  end
endmodule
`default_nettype wire
